// ==== rtl/hcs_defines.svh ====
// constants for the per-channel status bank: offsets, field positions, reset values
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef HCS_DEFINES_SVH
`define HCS_DEFINES_SVH
`define HCS_OFS_STAT_A 16'h7008
`define HCS_OFS_STAT_B 16'h8008
`define HCS_OFS_MASK_A 16'h700C
`define HCS_OFS_MASK_B 16'h800C
`define HCS_STAT_RESET 11'h000
`define HCS_BIT_TX_FRAME_COMPLETE 4
`define HCS_BIT_TX_SPACE_AVAILABLE 5
`define HCS_BIT_CTS 6
`define HCS_BIT_SCTS 7
`define HCS_BIT_TXU 8
`define HCS_BIT_RX_DATA_AVAILABLE 9
`define HCS_STICKY_MASK 11'h190
`define HCS_RX_REMAINING_BYTE_COUNT_W1_MAX 4'h3
`define HCS_RX_LAST_MIN_WORDS 3'h2
`define HCS_RX_GROUP_WORDS 3'h4
`define HCS_TX_GROUP_WORDS 3'h4
`define HCS_ADDR_W 16
`endif

// ==== rtl/hcs_pkg.sv ====
// types for the per-channel status bank
// assumes hcs_defines.svh for the numeric constants
package hcs_pkg;
    // live conditions reported by one channel's transmitter and receiver
    typedef struct packed {
        logic four_word_mode;
        logic tx_dma_on;
        logic rx_dma_on;
        logic [2:0] tx_free_words;
        logic tx_queue_empty;
        logic tx_end_sent;
        logic tx_underrun;
        logic [2:0] rx_words;
        logic rx_last_marker;
        logic rx_frame_done;
        logic [3:0] rx_valid_bytes;
    } hcs_chan_in_t;

    typedef enum logic [1:0] {
        HCS_SEL_STAT_A,
        HCS_SEL_STAT_B,
        HCS_SEL_MASK_A,
        HCS_SEL_MASK_B
    } hcs_sel_t;
endpackage

// ==== rtl/hcs_status_bank.sv ====
// status registers for two serial channels, bits 0..10, with interrupt mask
// assumes classic wishbone master on core_clk; clear-to-send pins are asynchronous
//
// The Wishbone register port was left to the implementer.
`include "hcs_defines.svh"

module hcs_status_bank
    import hcs_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [`HCS_ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire hcs_chan_in_t chan_a_in,
    input wire hcs_chan_in_t chan_b_in,
    input wire logic clear_to_send_pin_n_a,
    input wire logic clear_to_send_pin_n_b,
    output logic tx_abort_req_a,
    output logic tx_abort_req_b,
    output logic irq
);
    logic [1:0] cts_meta_r, cts_sync_r, cts_prev_r;
    logic [1:0] cts_meta_nxt, cts_sync_nxt, cts_prev_nxt;
    logic [10:0] stat_r [2];
    logic [10:0] stat_nxt [2];
    logic [10:0] stat_set [2];
    logic [10:0] mask_r [2];
    logic [10:0] mask_nxt [2];
    logic [31:0] dat_r, dat_nxt;
    logic ack_r, ack_nxt, err_r, err_nxt, irq_r, irq_nxt;
    logic [1:0] abort_r, abort_nxt;
    hcs_chan_in_t cin [2];
    logic req, hit, wr_lane_lo;
    hcs_sel_t sel;

    assign cin[0] = chan_a_in;
    assign cin[1] = chan_b_in;

    // live and sticky status for one channel, excluding software clear
    function automatic logic [10:0] chan_stat(input hcs_chan_in_t c, input logic [10:0] cur,
                                              input logic cts_now, input logic cts_old);
        logic [10:0] s;
        logic [2:0] need_tx;
        logic rx_ok;
        s = cur & `HCS_STICKY_MASK;
        // remaining count latched on frame completion, width limited by mode
        if (c.rx_frame_done) begin
            s[3:0] = c.four_word_mode ? c.rx_valid_bytes
                   : (c.rx_valid_bytes & `HCS_RX_REMAINING_BYTE_COUNT_W1_MAX);
        end else begin
            s[3:0] = cur[3:0];
        end
        if (c.tx_queue_empty && c.tx_end_sent) begin
            s[`HCS_BIT_TX_FRAME_COMPLETE] = 1'b1;
        end
        need_tx = c.four_word_mode ? `HCS_TX_GROUP_WORDS : 3'h1;
        s[`HCS_BIT_TX_SPACE_AVAILABLE] = !c.tx_dma_on && (c.tx_free_words >= need_tx);
        s[`HCS_BIT_CTS] = cts_now;
        if (cts_now != cts_old) begin
            s[`HCS_BIT_SCTS] = 1'b1;
        end
        if (c.tx_underrun) begin
            s[`HCS_BIT_TXU] = 1'b1;
        end
        rx_ok = c.four_word_mode ? (c.rx_words >= `HCS_RX_GROUP_WORDS) : (c.rx_words != 3'h0);
        if (c.rx_last_marker && c.rx_words >= `HCS_RX_LAST_MIN_WORDS) begin
            rx_ok = 1'b1;
        end
        s[`HCS_BIT_RX_DATA_AVAILABLE] = !c.rx_dma_on && rx_ok;
        s[10] = 1'b0;
        return s;
    endfunction

    assign req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
    assign wr_lane_lo = wb_sel_i[0] && wb_sel_i[1];

    always_comb begin
        hit = 1'b1;
        sel = HCS_SEL_STAT_A;
        case (wb_adr_i)
            `HCS_OFS_STAT_A: sel = HCS_SEL_STAT_A;
            `HCS_OFS_STAT_B: sel = HCS_SEL_STAT_B;
            `HCS_OFS_MASK_A: sel = HCS_SEL_MASK_A;
            `HCS_OFS_MASK_B: sel = HCS_SEL_MASK_B;
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        logic [10:0] wclr;
        wclr = 11'h000;
        cts_meta_nxt = {~clear_to_send_pin_n_b, ~clear_to_send_pin_n_a};
        cts_sync_nxt = cts_meta_r;
        cts_prev_nxt = cts_sync_r;
        for (int i = 0; i < 2; i++) begin
            stat_nxt[i] = chan_stat(cin[i], stat_r[i], cts_sync_r[i], cts_prev_r[i]);
            // sticky events raised this cycle, so a clear cannot swallow a repeat event
            stat_set[i] = chan_stat(cin[i], 11'h000, cts_sync_r[i], cts_prev_r[i]) & `HCS_STICKY_MASK;
            mask_nxt[i] = mask_r[i];
            abort_nxt[i] = cin[i].tx_underrun;
        end
        // write-one clears only sticky bits; set in the same cycle wins
        if (req && hit && wb_we_i && wr_lane_lo) begin
            wclr = wb_dat_i[10:0] & `HCS_STICKY_MASK;
            case (sel)
                HCS_SEL_STAT_A: stat_nxt[0] = stat_nxt[0] & ~(wclr & ~stat_set[0]);
                HCS_SEL_STAT_B: stat_nxt[1] = stat_nxt[1] & ~(wclr & ~stat_set[1]);
                HCS_SEL_MASK_A: mask_nxt[0] = wb_dat_i[10:0] & `HCS_STICKY_MASK;
                HCS_SEL_MASK_B: mask_nxt[1] = wb_dat_i[10:0] & `HCS_STICKY_MASK;
                default: wclr = 11'h000;
            endcase
        end
        ack_nxt = req && hit;
        err_nxt = req && !hit;
        dat_nxt = 32'h0000_0000;
        // reads are side-effect free
        if (req && hit && !wb_we_i) begin
            case (sel)
                HCS_SEL_STAT_A: dat_nxt = {21'h0, stat_r[0]};
                HCS_SEL_STAT_B: dat_nxt = {21'h0, stat_r[1]};
                HCS_SEL_MASK_A: dat_nxt = {21'h0, mask_r[0]};
                HCS_SEL_MASK_B: dat_nxt = {21'h0, mask_r[1]};
                default: dat_nxt = 32'h0000_0000;
            endcase
        end
        // only sticky events interrupt; level bits never do
        irq_nxt = |(stat_nxt[0] & mask_nxt[0] & `HCS_STICKY_MASK)
               || |(stat_nxt[1] & mask_nxt[1] & `HCS_STICKY_MASK);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cts_meta_r <= 2'h0;
            cts_sync_r <= 2'h0;
            cts_prev_r <= 2'h0;
            stat_r[0] <= `HCS_STAT_RESET;
            stat_r[1] <= `HCS_STAT_RESET;
            mask_r[0] <= 11'h000;
            mask_r[1] <= 11'h000;
            dat_r <= 32'h0000_0000;
            ack_r <= 1'b0;
            err_r <= 1'b0;
            irq_r <= 1'b0;
            abort_r <= 2'h0;
        end else begin
            cts_meta_r <= cts_meta_nxt;
            cts_sync_r <= cts_sync_nxt;
            cts_prev_r <= cts_prev_nxt;
            stat_r[0] <= stat_nxt[0];
            stat_r[1] <= stat_nxt[1];
            mask_r[0] <= mask_nxt[0];
            mask_r[1] <= mask_nxt[1];
            dat_r <= dat_nxt;
            ack_r <= ack_nxt;
            err_r <= err_nxt;
            irq_r <= irq_nxt;
            abort_r <= abort_nxt;
        end
    end

    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;
    assign wb_err_o = err_r;
    assign irq = irq_r;
    assign tx_abort_req_a = abort_r[0];
    assign tx_abort_req_b = abort_r[1];
endmodule

// ==== bench/hcs_status_bank_monitor.sv ====
// checker for the status bank: bus answer timing, read-data width, abort requests, dma-forced zeros
// bound to hcs_status_bank; sees its ports only
module hcs_status_bank_monitor
    import hcs_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [15:0] wb_adr_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire hcs_chan_in_t chan_a_in,
    input wire logic tx_abort_req_a,
    input wire hcs_chan_in_t chan_b_in,
    input wire logic tx_abort_req_b
);
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
    sequence s_rd_a; wb_ack_o && !wb_we_i && wb_adr_i == 16'h7008; endsequence
    property p_answer; s_req |=> wb_ack_o || wb_err_o; endproperty
    a_answer: assert property (p_answer) else $error("bus answer late");
    property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
    property p_mapped; s_req ##0 wb_adr_i inside {16'h7008, 16'h8008, 16'h700C, 16'h800C} |=> !wb_err_o; endproperty
    a_mapped: assert property (p_mapped) else $error("error on a mapped address");
    property p_rsv; wb_ack_o |-> wb_dat_o[31:10] == 22'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
    property p_abort; chan_a_in.tx_underrun |=> tx_abort_req_a; endproperty
    a_abort: assert property (p_abort) else $error("no abort after underrun");
    property p_abort_b; chan_b_in.tx_underrun |=> tx_abort_req_b; endproperty
    a_abort_b: assert property (p_abort_b) else $error("no abort after underrun on b");
    property p_cause; tx_abort_req_a |-> $past(chan_a_in.tx_underrun); endproperty
    a_cause: assert property (p_cause) else $error("abort without underrun");
    property p_txdma; s_rd_a ##0 $past(chan_a_in.tx_dma_on, 3) && $past(chan_a_in.tx_dma_on, 2)
        && $past(chan_a_in.tx_dma_on) |-> !wb_dat_o[5]; endproperty
    a_txdma: assert property (p_txdma) else $error("tx space set during dma");
    property p_rxdma; s_rd_a ##0 $past(chan_a_in.rx_dma_on, 3) && $past(chan_a_in.rx_dma_on, 2)
        && $past(chan_a_in.rx_dma_on) |-> !wb_dat_o[9]; endproperty
    a_rxdma: assert property (p_rxdma) else $error("rx data set during dma");
endmodule
bind hcs_status_bank hcs_status_bank_monitor i_hcs_status_bank_monitor (.core_clk, .reset, .wb_adr_i, .wb_we_i,
    .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .chan_a_in, .tx_abort_req_a, .chan_b_in, .tx_abort_req_b);

// ==== bench/tb.sv ====
// bench for the status bank: bus access, clear-to-send, sticky and level bits, irq
// drives every port on core_clk rising edges; channel b conditions stay idle except for one tx_underrun pulse
module tb
    import hcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] sta = 16'h7008;
    logic core_clk = 1'h0, reset = 1'h1, we = 1'h0, cyc = 1'h0, stb = 1'h0, e;
    logic [15:0] adr = 16'h0;
    logic [31:0] dw = 32'h0;
    logic [1:0] pin_n = 2'h3;
    hcs_chan_in_t ca = '0;
    hcs_chan_in_t cb = '0;
    logic [3:0] sl = 4'hF;
    wire logic ack, err, irq, ab;
    wire logic [31:0] q;
    int fails = 0, compares = 0;
    hcs_status_bank i_hcs_status_bank (.core_clk, .reset, .wb_adr_i(adr), .wb_dat_i(dw), .wb_sel_i(sl),
        .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(q), .wb_ack_o(ack), .wb_err_o(err), .chan_a_in(ca),
        .chan_b_in(cb), .clear_to_send_pin_n_a(pin_n[0]), .clear_to_send_pin_n_b(pin_n[1]), .tx_abort_req_a(),
        .tx_abort_req_b(ab), .irq);
    initial forever #20 core_clk = ~core_clk;
    initial begin
        repeat (4000) @(posedge core_clk);
        fails++;
        end_of_test();
    end
    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            fails++;
            $display("FAIL t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    // one classic cycle held until ack or err; read data compared unless refused
    task automatic wb(input logic [15:0] a, input logic [31:0] x, input logic w = 1'h0, input logic [31:0] d = 32'h0);
        @(posedge core_clk);
        adr <= a;
        we <= w;
        dw <= d;
        cyc <= 1'h1;
        stb <= 1'h1;
        do @(posedge core_clk); while (ack !== 1'h1 && err !== 1'h1);
        e = err;
        cyc <= 1'h0;
        stb <= 1'h0;
        if (!w && err !== 1'h1) chk(q, x);
    endtask
    // apply conditions, drop the one-cycle pulses, let the status settle
    task automatic drv(input hcs_chan_in_t v);
        @(posedge core_clk);
        ca <= v;
        @(posedge core_clk);
        ca.rx_frame_done <= 1'h0;
        ca.tx_end_sent <= 1'h0;
        ca.tx_underrun <= 1'h0;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic t_cts(input int c, input logic [15:0] a);
        wb(a, 32'h0);
        pin_n[c] <= 1'h0;
        repeat (5) @(posedge core_clk);
        wb(a, 32'hC0);
        wb(a, 32'hC0);
        wb(a, 32'h0, 1'h1, 32'h80);
        wb(a, 32'h40);
        pin_n[c] <= 1'h1;
        repeat (5) @(posedge core_clk);
        wb(a, 32'h0, 1'h1, 32'h0);
        wb(a, 32'h80);
        wb(a, 32'h0, 1'h1, 32'h80);
        wb(a, 32'h0);
        $display("cts test on channel %0d done", c);
    endtask
    task automatic t_chan();
        drv('{tx_free_words: 3'h1, rx_words: 3'h1, rx_valid_bytes: 4'hE, rx_frame_done: 1'h1, default: '0});
        wb(sta, 32'h222);
        wb(sta, 32'h0, 1'h1, 32'h7FF);
        wb(sta, 32'h222);
        drv('{four_word_mode: 1'h1, tx_free_words: 3'h1, rx_words: 3'h2, rx_valid_bytes: 4'hE,
            rx_frame_done: 1'h1, default: '0});
        wb(sta, 32'h00E);
        drv('{four_word_mode: 1'h1, tx_free_words: 3'h4, rx_words: 3'h2, rx_last_marker: 1'h1, default: '0});
        wb(sta, 32'h22E);
        drv('{four_word_mode: 1'h1, tx_dma_on: 1'h1, rx_dma_on: 1'h1, tx_free_words: 3'h4, rx_words: 3'h4,
            default: '0});
        wb(sta, 32'h00E);
        wb(16'h700C, 32'h0, 1'h1, 32'h110);
        drv('{four_word_mode: 1'h1, tx_queue_empty: 1'h1, tx_end_sent: 1'h1, tx_underrun: 1'h1, default: '0});
        wb(sta, 32'h11E);
        chk({31'h0, irq}, 32'h1);
        wb(sta, 32'h0, 1'h1, 32'h10);
        wb(sta, 32'h10E);
        wb(sta, 32'h0, 1'h1, 32'h100);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        wb(16'h7004, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("channel condition test done");
    endtask
    // underrun on channel b: abort pulse, sticky bit, masked irq, lane-qualified clear
    task automatic t_chan_b();
        @(posedge core_clk);
        cb.tx_underrun <= 1'h1;
        @(posedge core_clk);
        cb.tx_underrun <= 1'h0;
        @(posedge core_clk);
        chk({31'h0, ab}, 32'h1);
        wb(16'h8008, 32'h100);
        wb(16'h800C, 32'h0, 1'h1, 32'h100);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        sl <= 4'hC;
        wb(16'h8008, 32'h0, 1'h1, 32'h100);
        sl <= 4'hF;
        wb(16'h8008, 32'h100);
        wb(16'h8008, 32'h0, 1'h1, 32'h100);
        wb(16'h8008, 32'h0);
        $display("channel b event test done");
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        reset <= 1'h0;
        t_cts(0, sta);
        t_cts(1, 16'h8008);
        t_chan();
        t_chan_b();
        end_of_test();
    end
endmodule
